// >>> agpbc_top.sv
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "agpbc_params.svh"
module agpbc_top import agpbc_pkg::*; (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire agpbc_ranges_s ranges,
  input wire agpbc_req_s frame_req,
  output logic frame_ready,
  output logic frame_claim,
  output logic frame_master_abort,
  output agpbc_hit_s frame_route,
  input wire agpbc_sba_s sba_req,
  output agpbc_sba_s sba_fwd,
  output logic master_accept_enable,
  output logic memory_window_enable,
  output logic io_window_enable
);
  // ==========================================================
  // register bus decode
  wire sel_cmd = (reg_addr == `AGPBC_OFF_CMD);
  wire sel_stat = (reg_addr == `AGPBC_OFF_STAT);
  wire sel_abcnt = (reg_addr == `AGPBC_OFF_ABCNT);
  wire sel_accnt = (reg_addr == `AGPBC_OFF_ACCNT);
  wire wr_cmd = reg_wr && sel_cmd;
  wire wr_stat = reg_wr && sel_stat;
  wire wr_abcnt = reg_wr && sel_abcnt;
  wire wr_accnt = reg_wr && sel_accnt;

  logic [15:0] cmd_view;

  // command register with its three enables
  agpbc_cmd_reg u_cmd (
    .mclk(mclk),
    .nrst(nrst),
    .wr_cmd(wr_cmd),
    .wdata(reg_wdata),
    .master_accept_enable(master_accept_enable),
    .memory_window_enable(memory_window_enable),
    .io_window_enable(io_window_enable),
    .cmd_view(cmd_view)
  );

  // ==========================================================
  // framed request capture
  agpbc_state_e state_r;
  agpbc_state_e state_nxt;
  logic [31:0] addr_r;
  logic [31:0] addr_nxt;
  logic is_io_r;
  logic is_io_nxt;
  agpbc_hit_s hit_now;
  logic hit_any;
  agpbc_hit_s route_r;
  agpbc_hit_s route_nxt;

  // a request is taken only when idle
  assign frame_ready = (state_r == AGPBC_IDLE);
  wire take = frame_req.valid && frame_ready;

  assign addr_nxt = take ? frame_req.addr : addr_r;
  assign is_io_nxt = take ? frame_req.is_io : is_io_r;

  // address decode against the forwarding windows
  agpbc_decode u_dec (
    .addr(addr_r),
    .is_io(is_io_r),
    .memory_window_enable(memory_window_enable),
    .io_window_enable(io_window_enable),
    .ranges(ranges),
    .hit(hit_now),
    .hit_any(hit_any)
  );

  // claim only with master accept enabled and a window hit
  wire accept = master_accept_enable && hit_any;

  // ==========================================================
  // decision state machine
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      AGPBC_IDLE: begin
        if (take) begin
          state_nxt = AGPBC_DECIDE;
        end
      end
      AGPBC_DECIDE: begin
        if (accept) begin
          state_nxt = AGPBC_CLAIM;
        end else begin
          state_nxt = AGPBC_ABORT;
        end
      end
      AGPBC_CLAIM: begin
        state_nxt = AGPBC_IDLE;
      end
      AGPBC_ABORT: begin
        state_nxt = AGPBC_IDLE;
      end
      default: begin
        state_nxt = AGPBC_IDLE;
      end
    endcase
  end

  // route is latched with the decision and cleared on abort
  assign route_nxt = (state_r == AGPBC_DECIDE) ?
                     (accept ? hit_now : 4'h0) : route_r;

  // state and captured request
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state_r <= AGPBC_IDLE;
      addr_r <= 32'h00000000;
      is_io_r <= 1'b0;
      route_r <= 4'h0;
    end else begin
      state_r <= state_nxt;
      addr_r <= addr_nxt;
      is_io_r <= is_io_nxt;
      route_r <= route_nxt;
    end
  end

  // answers come straight from the state flops
  assign frame_claim = (state_r == AGPBC_CLAIM);
  assign frame_master_abort = (state_r == AGPBC_ABORT);
  assign frame_route = route_r;

  // ==========================================================
  // sideband and pipelined requests, never gated
  agpbc_sba_s sba_r;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sba_r <= '0;
    end else begin
      sba_r <= sba_req;
    end
  end

  assign sba_fwd = sba_r;

  // ==========================================================
  // decision statistics
  function automatic logic [7:0] cnt_step(input logic [7:0] c, input logic inc,
                                          input logic clr);
    logic [7:0] base;
    base = clr ? 8'h00 : c;
    cnt_step = (inc && base != 8'hFF) ? base + 8'h01 : base;
  endfunction

  logic [7:0] abcnt_r;
  logic [7:0] abcnt_nxt;
  logic [7:0] accnt_r;
  logic [7:0] accnt_nxt;
  logic abort_seen_r;
  logic abort_seen_nxt;
  logic claim_seen_r;
  logic claim_seen_nxt;

  // counters saturate; a clear in the count cycle still keeps the event
  assign abcnt_nxt = cnt_step(abcnt_r, frame_master_abort, wr_abcnt);
  assign accnt_nxt = cnt_step(accnt_r, frame_claim, wr_accnt);

  // sticky flags, write one to clear, a new event wins
  assign abort_seen_nxt = frame_master_abort ||
                          (abort_seen_r && !(wr_stat && reg_wdata[0]));
  assign claim_seen_nxt = frame_claim ||
                          (claim_seen_r && !(wr_stat && reg_wdata[1]));

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      abcnt_r <= `AGPBC_CNT_RST;
      accnt_r <= `AGPBC_CNT_RST;
      abort_seen_r <= 1'b0;
      claim_seen_r <= 1'b0;
    end else begin
      abcnt_r <= abcnt_nxt;
      accnt_r <= accnt_nxt;
      abort_seen_r <= abort_seen_nxt;
      claim_seen_r <= claim_seen_nxt;
    end
  end

  // ==========================================================
  // read data, one cycle after the strobe
  wire [15:0] stat_view = {8'h00, 3'h0, memory_window_enable, io_window_enable,
                           frame_ready, claim_seen_r, abort_seen_r};
  wire [15:0] rd_sel = sel_cmd ? cmd_view :
                       sel_stat ? stat_view :
                       sel_abcnt ? {8'h00, abcnt_r} :
                       sel_accnt ? {8'h00, accnt_r} : 16'h0000;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;

  // data stands only in the cycle after the strobe
  assign rdata_nxt = reg_rd ? rd_sel : 16'h0000;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;
endmodule

// >>> agpbc_params.svh
// ==========================================================
`ifndef AGPBC_PARAMS_SVH
`define AGPBC_PARAMS_SVH
// ==========================================================
// register offsets
`define AGPBC_OFF_CMD 8'h04
`define AGPBC_OFF_STAT 8'hF0
`define AGPBC_OFF_ABCNT 8'hF4
`define AGPBC_OFF_ACCNT 8'hF8
// ==========================================================
// command field positions
`define AGPBC_BIT_IO 0
`define AGPBC_BIT_MEM 1
`define AGPBC_BIT_BME 2
// ==========================================================
// reset values
`define AGPBC_CMD_RST 3'h0
`define AGPBC_CNT_RST 8'h00
// ==========================================================
// vga window, address bits 31:17
`define AGPBC_VGA_TAG 15'h0005
`endif

// >>> agpbc_pkg.sv
package agpbc_pkg;
  // framed request from the secondary-side master
  typedef struct packed {
    logic valid;
    logic is_io;
    logic is_write;
    logic [31:0] addr;
  } agpbc_req_s;
  // sideband or pipelined request
  typedef struct packed {
    logic valid;
    logic is_pipe;
    logic [31:0] addr;
  } agpbc_sba_s;
  // forwarding ranges held elsewhere in the bridge
  typedef struct packed {
    logic [15:0] mem_range_base;
    logic [15:0] mem_range_limit;
    logic [15:0] prefetch_range_base;
    logic [15:0] prefetch_range_limit;
    logic [7:0] io_range_base;
    logic [7:0] io_range_limit;
  } agpbc_ranges_s;
  // decode hits
  typedef struct packed {
    logic mem;
    logic pref;
    logic vga;
    logic io;
  } agpbc_hit_s;
  typedef enum logic [3:0] {
    AGPBC_IDLE = 4'h1,
    AGPBC_DECIDE = 4'h2,
    AGPBC_CLAIM = 4'h4,
    AGPBC_ABORT = 4'h8
  } agpbc_state_e;
endpackage

// >>> agpbc_cmd_reg.sv
`timescale 1ns/1ps
`include "agpbc_params.svh"
module agpbc_cmd_reg import agpbc_pkg::*; (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic wr_cmd,
  input wire logic [15:0] wdata,
  output logic master_accept_enable,
  output logic memory_window_enable,
  output logic io_window_enable,
  output logic [15:0] cmd_view
);
  logic [2:0] en_r;
  logic [2:0] en_nxt;

  // only the three enables take write data
  assign en_nxt = wr_cmd ? wdata[2:0] : en_r;

  // ==========================================================
  // storage
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      en_r <= `AGPBC_CMD_RST;
    end else begin
      en_r <= en_nxt;
    end
  end

  assign master_accept_enable = en_r[`AGPBC_BIT_BME];
  assign memory_window_enable = en_r[`AGPBC_BIT_MEM];
  assign io_window_enable = en_r[`AGPBC_BIT_IO];

  // read view: upper byte and bits 7:3 are constant zero
  assign cmd_view = {8'h00, 1'b0,
                     1'b0,
                     1'b0,
                     2'b00,
                     en_r};
endmodule

// >>> agpbc_decode.sv
`timescale 1ns/1ps
`include "agpbc_params.svh"
module agpbc_decode import agpbc_pkg::*; (
  input wire logic [31:0] addr,
  input wire logic is_io,
  input wire logic memory_window_enable,
  input wire logic io_window_enable,
  input wire agpbc_ranges_s ranges,
  output agpbc_hit_s hit,
  output logic hit_any
);
  // inclusive window compare on upper address bits
  function automatic logic in_win(input logic [11:0] a, input logic [11:0] lo,
                                  input logic [11:0] hi);
    in_win = (a >= lo) && (a <= hi);
  endfunction

  wire mem_raw = in_win(addr[31:20], ranges.mem_range_base[15:4],
                        ranges.mem_range_limit[15:4]);
  wire pref_raw = in_win(addr[31:20], ranges.prefetch_range_base[15:4],
                         ranges.prefetch_range_limit[15:4]);
  wire vga_raw = (addr[31:17] == `AGPBC_VGA_TAG);
  wire io_raw = (addr[31:16] == 16'h0000) &&
                in_win({8'h00, addr[15:12]}, {8'h00, ranges.io_range_base[7:4]},
                       {8'h00, ranges.io_range_limit[7:4]});

  // memory space gated by the memory window enable
  assign hit.mem = !is_io && memory_window_enable && mem_raw;
  assign hit.pref = !is_io && memory_window_enable && pref_raw;
  assign hit.vga = !is_io && memory_window_enable && vga_raw;
  // io space gated by the io window enable
  assign hit.io = is_io && io_window_enable && io_raw;
  assign hit_any = hit.mem | hit.pref | hit.vga | hit.io;
endmodule

// >>> agpbc_top_monitor.sv
`timescale 1ns/1ps
module agpbc_top_monitor import agpbc_pkg::*; (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire agpbc_req_s frame_req,
  input wire logic frame_ready,
  input wire logic frame_claim,
  input wire logic frame_master_abort,
  input wire agpbc_hit_s frame_route,
  input wire agpbc_sba_s sba_req,
  input wire agpbc_sba_s sba_fwd,
  input wire logic master_accept_enable,
  input wire logic memory_window_enable,
  input wire logic io_window_enable
);
  // ==========================================================
  // frame handshake steps, command register access and sideband forwarding
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence s_take;
    frame_req.valid && frame_ready;
  endsequence
  sequence s_done;
    frame_claim ^ frame_master_abort;
  endsequence
  property p_answer;
    s_take |-> ##2 s_done;
  endproperty
  property p_abort_off;
    s_take ##1 !master_accept_enable |=> frame_master_abort;
  endproperty
  property p_claim_acc;
    frame_claim |-> $past(master_accept_enable) && frame_route != 4'h0;
  endproperty
  property p_abort_route;
    frame_master_abort |-> frame_route == 4'h0;
  endproperty
  property p_mem_gate;
    frame_claim && (frame_route.mem || frame_route.pref || frame_route.vga)
      |-> $past(memory_window_enable);
  endproperty
  property p_io_gate;
    frame_claim && frame_route.io |-> $past(io_window_enable);
  endproperty
  property p_low_zero;
    reg_rd && reg_addr == 8'h04 |=> reg_rdata[15:3] == 13'h0000;
  endproperty
  property p_wr_cmd;
    reg_wr && reg_addr == 8'h04 |=> {13'h0000, master_accept_enable, memory_window_enable,
      io_window_enable} == ($past(reg_wdata) & 16'h0007);
  endproperty
  property p_sba;
    sba_req.valid |=> sba_fwd == $past(sba_req);
  endproperty
  a_answer: assert property (p_answer) else $error("frame answer missing");
  a_abort_off: assert property (p_abort_off) else $error("frame not aborted");
  a_claim_acc: assert property (p_claim_acc) else $error("claim without accept");
  a_abort_route: assert property (p_abort_route) else $error("route on abort");
  a_mem_gate: assert property (p_mem_gate) else $error("memory hit while off");
  a_io_gate: assert property (p_io_gate) else $error("io hit while off");
  a_low_zero: assert property (p_low_zero) else $error("fixed bits nonzero");
  a_wr_cmd: assert property (p_wr_cmd) else $error("enables not written");
  a_sba: assert property (p_sba) else $error("sideband not forwarded");
endmodule
bind agpbc_top agpbc_top_monitor u_mon (.mclk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .frame_req, .frame_ready, .frame_claim, .frame_master_abort,
  .frame_route, .sba_req, .sba_fwd, .master_accept_enable, .memory_window_enable,
  .io_window_enable);

// >>> agpbc_agp_master.sv
`timescale 1ns/1ps
module agpbc_agp_master import agpbc_pkg::*; (
  input wire logic mclk,
  input wire logic go,
  input wire logic go_io,
  input wire logic [31:0] go_addr,
  input wire logic frame_ready,
  output agpbc_req_s frame_req
);
  initial frame_req = '0;
  // one framed request per go, dropped after the taking edge
  always @(posedge mclk) begin
    if (frame_req.valid && frame_ready) begin
      frame_req.valid <= 1'b0;
      frame_req.addr <= ~frame_req.addr;
    end else if (go) begin
      frame_req <= '{1'b1, go_io, 1'b0, go_addr};
    end
  end
endmodule

// >>> test_agp_bridge_command_low_byte.sv
`timescale 1ns/1ps
module test_agp_bridge_command_low_byte import agpbc_pkg::*;;
  typedef struct {
    logic [15:0] cmd;
    logic io;
    logic [31:0] a;
    logic cl;
    logic [3:0] rt;
  } agpbc_row_s;
  logic mclk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, go = 0, go_io = 0;
  logic [7:0] reg_addr = '0;
  logic [15:0] reg_wdata = '0;
  logic [31:0] go_addr = '0;
  agpbc_ranges_s ranges = '{16'h1000, 16'h1FF0, 16'h4000, 16'h4FF0, 8'h20, 8'h30};
  agpbc_sba_s sba_req = '0;
  agpbc_sba_s sba_fwd;
  agpbc_req_s frame_req;
  agpbc_hit_s frame_route;
  logic [15:0] reg_rdata;
  logic frame_ready, frame_claim, frame_master_abort, mae, mwe, iwe;
  int error_cnt = 0;
  int cmp_count = 0;
  agpbc_row_s rows [9] = '{
    '{16'hFFFF, 1'b0, 32'h1000_0000, 1'b1, 4'h8}, '{16'h0007, 1'b0, 32'h4000_0000, 1'b1, 4'h4},
    '{16'h0007, 1'b0, 32'h000A_0000, 1'b1, 4'h2}, '{16'h0007, 1'b1, 32'h0000_2000, 1'b1, 4'h1},
    '{16'h0003, 1'b0, 32'h1000_0000, 1'b0, 4'h0}, '{16'h0005, 1'b0, 32'h1000_0000, 1'b0, 4'h0},
    '{16'h0006, 1'b1, 32'h0000_2000, 1'b0, 4'h0}, '{16'h0007, 1'b0, 32'h2000_0000, 1'b0, 4'h0},
    '{16'h00F8, 1'b0, 32'h1000_0000, 1'b0, 4'h0}};
  always #5 mclk = ~mclk;
  agpbc_top dut (.mclk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ranges,
    .frame_req, .frame_ready, .frame_claim, .frame_master_abort, .frame_route, .sba_req,
    .sba_fwd, .master_accept_enable(mae), .memory_window_enable(mwe), .io_window_enable(iwe));
  agpbc_agp_master u_agp (.mclk, .go, .go_io, .go_addr, .frame_ready, .frame_req);
  // ==========================================================
  // shared tasks
  task automatic chk(string n, logic [33:0] s, logic [33:0] e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [15:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk("rdata", reg_rdata, e);
  endtask
  task automatic frm(logic io, logic [31:0] a, logic cl, logic [3:0] rt);
    logic seen;
    seen = 0;
    @(posedge mclk);
    go <= 1'b1;
    go_io <= io;
    go_addr <= a;
    @(posedge mclk);
    go <= 1'b0;
    repeat (8) begin
      @(posedge mclk);
      #1;
      if (!seen && (frame_claim || frame_master_abort)) begin
        seen = 1;
        chk("claim", frame_claim, cl);
        chk("route", frame_route, rt);
        chk("ready", frame_ready, 1'b0);
      end
    end
    chk("answered", seen, 1'b1);
  endtask
  task automatic sba(logic [31:0] a);
    @(posedge mclk);
    sba_req <= '{1'b1, 1'b0, a};
    @(posedge mclk);
    sba_req <= '{1'b0, 1'b1, ~a};
    #1 chk("sba", sba_fwd, {1'b1, 1'b0, a});
  endtask
  task automatic summarize;
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    rd(8'h04, 16'h0000);
    foreach (rows[i]) begin
      wr(8'h04, rows[i].cmd);
      rd(8'h04, rows[i].cmd & 16'h0007);
      frm(rows[i].io, rows[i].a, rows[i].cl, rows[i].rt);
      sba(rows[i].a);
      $display("test %0d done", i);
    end
    rd(8'hF0, 16'h0007);
    rd(8'hF4, 16'h0005);
    rd(8'hF8, 16'h0004);
    wr(8'hF0, 16'h0002);
    rd(8'hF0, 16'h0005);
    $display("test counts done");
    wr(8'h40, 16'hFFFF);
    rd(8'h40, 16'h0000);
    wr(8'h04, 16'h0007);
    @(posedge mclk);
    nrst <= 1'b0;
    @(posedge mclk);
    nrst <= 1'b1;
    #1 chk("enables", {mae, mwe, iwe}, 3'h0);
    frm(1'b0, 32'h1000_0000, 1'b0, 4'h0);
    rd(8'hF0, 16'h0005);
    wr(8'hF0, 16'h0001);
    wr(8'hF4, 16'h0000);
    wr(8'h04, 16'h0003);
    rd(8'hF0, 16'h001C);
    rd(8'hF4, 16'h0000);
    $display("test reset done");
    summarize;
  end
  // watchdog against a hang
  initial begin
    #20000;
    error_cnt++;
    summarize;
  end
endmodule
